//--- core/asr_receiver.sv
`timescale 1ns/10ps
module asr_receiver (
   input  wire logic        clk,                  // System clock, 50 MHz
   input  wire logic        rst_n,                // Async reset, active low
   input  wire logic        serial_bit_clock,     // Link bit clock
   input  wire logic        frame_sync,           // Frame sync, bit clock domain
   input  wire logic        serial_data_in_1,     // Serial data line 1
   input  wire logic        serial_data_in_2,     // Serial data line 2
   input  wire logic        master_audio_clock,   // Master audio clock
   input  wire logic        paralleled_bridge_12, // Channels 1/2 bridged
   input  wire logic        paralleled_bridge_34, // Channels 3/4 bridged
   input  wire logic [7:0]  reg_addr,             // Register address
   input  wire logic        reg_wr_en,            // Register write strobe
   input  wire logic        reg_rd_en,            // Register read strobe
   input  wire logic [7:0]  reg_wdata,            // Register write data
   output logic      [7:0]  reg_rdata,            // Read data, next cycle
   output logic      [31:0] ch_sample_1,          // Channel 1 sample
   output logic      [31:0] ch_sample_2,          // Channel 2 sample
   output logic      [31:0] ch_sample_3,          // Channel 3 sample
   output logic      [31:0] ch_sample_4,          // Channel 4 sample
   output logic             sample_valid,         // One pulse per good frame
   output logic             channels_hiz          // All channels high impedance
);
   logic [7:0]                     spc_q;
   logic [7:0]                     pbs_q;
   logic [asr_pkg::CFG_W-1:0]      cfg_l;
   asr_pkg::asr_fmt_t              fmt_l;
   asr_pkg::asr_wlen_t             wl_l;
   logic                           tdm_l;
   logic                           lj_l;
   logic                           fs_q;
   logic [asr_pkg::CNT_W-1:0]      cnt_q;
   logic [asr_pkg::CNT_W-1:0]      d_idx_l;
   logic [asr_pkg::CNT_W-1:0]      tdm_bits_l;
   logic                           change_l;
   logic                           restart_l;
   logic                           owner_l;
   logic                           left_l;
   logic [4:0]                     last_l;
   logic [4:0]                     bit_l;
   logic [2:0]                     slot_l;
   logic [2:0]                     base_l;
   logic [2:0]                     map_l [4];
   logic                           cap_stereo_l;
   logic                           cap_tdm_l;
   logic                           frame_evt_l;
   logic [31:0]                    sh1_q;
   logic [31:0]                    sh2_q;
   logic [31:0]                    word1_l;
   logic [31:0]                    word2_l;
   logic [31:0]                    hold_q [4];
   logic [31:0]                    outl_q [4];
   logic [asr_pkg::CNT_W-1:0]      flen_q;
   logic                           pub_q;
   logic                           ftgl_q;
   logic [asr_pkg::MCLK_DIV_W-1:0] mdiv_q;
   logic                           ftgl_s;
   logic                           mtgl_s;
   logic                           ftgl_p_q;
   logic                           mtgl_p_q;
   logic                           new_frame;
   logic [7:0]                     mcnt_q;
   logic [asr_pkg::HALT_W-1:0]     halt_cnt_q;
   logic                           halt_w;
   logic                           len_good;
   logic                           mclk_good;
   logic                           good_w;
   logic                           frame_ok_q;

   // Control registers, writes masked so reserved bits stay zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         spc_q <= asr_pkg::SPC_RESET;                                   // [RL21]
         pbs_q <= asr_pkg::PBS_RESET;
      end else if (reg_wr_en) begin
         if (reg_addr == asr_pkg::SPC_ADDR) begin
            spc_q <= reg_wdata & asr_pkg::SPC_RW_MASK;                  // [RL21]
         end
         if (reg_addr == asr_pkg::PBS_ADDR) begin
            pbs_q <= reg_wdata & asr_pkg::PBS_RW_MASK;                  // [RL20]
         end
      end
   end

   // Read port, unmapped addresses answer zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd_en) begin
         if (reg_addr == asr_pkg::SPC_ADDR) begin
            reg_rdata <= spc_q;
         end else if (reg_addr == asr_pkg::PBS_ADDR) begin
            reg_rdata <= pbs_q;
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // Settings are quasi-static; change them only while the stream is idle
   asr_sync #(.W(asr_pkg::CFG_W)) u_cfg_sync (
      .clk   (serial_bit_clock),
      .rst_n (rst_n),
      .d     ({paralleled_bridge_34, paralleled_bridge_12,
               pbs_q[asr_pkg::PBS_EVEN_BIT], spc_q}),
      .q     (cfg_l)
   );

   // Decoded link-side settings
   assign fmt_l = asr_pkg::asr_fmt_t'(cfg_l[asr_pkg::SPC_FMT_HI:asr_pkg::SPC_FMT_LO]);  // [RL1]
   assign wl_l  = asr_pkg::asr_wlen_t'(cfg_l[asr_pkg::SPC_WLEN_HI:asr_pkg::SPC_WLEN_LO]);
   assign tdm_l = (fmt_l == asr_pkg::ASR_FMT_TDM);
   assign lj_l  = (fmt_l == asr_pkg::ASR_FMT_LJ);

   // Left-align a word; anything above it in the shifter is dropped
   function automatic logic [31:0] asr_align(input logic [31:0] v,
                                             input asr_pkg::asr_wlen_t wl);
      logic [31:0] r;
      r = v;
      unique case (wl)
         asr_pkg::ASR_WL_16:  r = {v[15:0], 16'h0000};
         asr_pkg::ASR_WL_32:  r = v;
         asr_pkg::ASR_WL_24,
         asr_pkg::ASR_WL_24B: r = {v[23:0], 8'h00};
      endcase
      return r;
   endfunction : asr_align

   // Frame boundaries: multiplexed frames restart on the rising sync edge only
   assign change_l    = frame_sync ^ fs_q;
   assign restart_l   = tdm_l ? (frame_sync & ~fs_q) : change_l;
   assign frame_evt_l = tdm_l ? restart_l :
                        (change_l & ((fmt_l == asr_pkg::ASR_FMT_I2S) ? ~frame_sync : frame_sync));

   // Bit index within the half-frame or frame; delayed modes lag by one clock
   assign d_idx_l = lj_l ? (restart_l ? '0 : cnt_q + 10'h001) : cnt_q;      // [RL4] [RL7]
   assign owner_l = lj_l ? frame_sync : fs_q;
   assign left_l  = (fmt_l == asr_pkg::ASR_FMT_I2S) ? ~owner_l : owner_l;   // [RL2] [RL6] [RL9]
   assign last_l  = (wl_l == asr_pkg::ASR_WL_16) ? asr_pkg::LAST_16 :  // [RL8] [RL14]
                    (wl_l == asr_pkg::ASR_WL_32) ? asr_pkg::LAST_32 : asr_pkg::LAST_24;
   assign bit_l   = (wl_l == asr_pkg::ASR_WL_16) ? {1'b0, d_idx_l[3:0]} : d_idx_l[4:0];
   assign slot_l  = (wl_l == asr_pkg::ASR_WL_16) ? d_idx_l[6:4] : d_idx_l[7:5];
   assign tdm_bits_l = cfg_l[asr_pkg::SPC_SLOTS8_BIT] ?  // [RL13]
                       ((wl_l == asr_pkg::ASR_WL_16) ? asr_pkg::EIGHT_SLOT_MULTIPLEX_16 : asr_pkg::EIGHT_SLOT_MULTIPLEX_32) :
                       ((wl_l == asr_pkg::ASR_WL_16) ? asr_pkg::TDM4_16 : asr_pkg::TDM4_32);

   // Right-justified words close at the sync change; others at their last bit
   assign cap_stereo_l = ~tdm_l & ((fmt_l == asr_pkg::ASR_FMT_RJ) ? change_l :
                                   (d_idx_l == {5'h00, last_l}));                 // [RL11]
   assign cap_tdm_l    = tdm_l & (d_idx_l < tdm_bits_l) & (bit_l == last_l);

   // Shift registers; RJ takes the low bits, so leading padding falls away
   assign word1_l = asr_align((fmt_l == asr_pkg::ASR_FMT_RJ) ? sh1_q :  // [RL10] [RL12]
                              {sh1_q[30:0], serial_data_in_1}, wl_l);
   assign word2_l = asr_align((fmt_l == asr_pkg::ASR_FMT_RJ) ? sh2_q :
                              {sh2_q[30:0], serial_data_in_2}, wl_l);

   // Sync history, bit counter and shifters, rising bit clock edge
   always_ff @(posedge serial_bit_clock or negedge rst_n) begin
      if (!rst_n) begin
         fs_q  <= 1'b0;
         cnt_q <= '0;
         sh1_q <= '0;
         sh2_q <= '0;
      end else begin
         fs_q  <= frame_sync;
         sh1_q <= {sh1_q[30:0], serial_data_in_1};                            // [RL5]
         sh2_q <= {sh2_q[30:0], serial_data_in_2};
         if (restart_l) begin
            cnt_q <= '0;
         end else if (cnt_q != '1) begin
            cnt_q <= cnt_q + 10'h001;
         end
      end
   end

   // Slot map: group base, pair swap, bridged pairs share one slot
   assign base_l = (cfg_l[asr_pkg::SPC_SLOTS8_BIT] & cfg_l[asr_pkg::SPC_GROUP_BIT]) ?
                   asr_pkg::GROUP_BASE : 3'h0;                                   // [RL19]
   for (genvar i = 0; i < 4; i++) begin : g_ch
      localparam logic [2:0] IDX = 3'(i);
      logic paralleled_bridge_mode;
      assign paralleled_bridge_mode = IDX[1] ? cfg_l[asr_pkg::CFG_PB34] : cfg_l[asr_pkg::CFG_PB12];
      // Bridged pair: odd/even choice from the slot register
      assign map_l[i] = base_l | (paralleled_bridge_mode ?
                        {1'b0, IDX[1] ^ cfg_l[asr_pkg::SPC_SWAP_BIT], cfg_l[asr_pkg::CFG_EVEN]} :
                        (IDX ^ (cfg_l[asr_pkg::SPC_SWAP_BIT] ?
                                asr_pkg::SWAP_FLIP : 3'h0)));  // [RL18] [RL20]

      // Multiplexed words come from line 1 only
      always_ff @(posedge serial_bit_clock or negedge rst_n) begin
         if (!rst_n) begin
            hold_q[i] <= '0;
         end else if (cap_tdm_l && (slot_l == map_l[i])) begin
            hold_q[i] <= word1_l;                                              // [RL17]
         end else if (cap_stereo_l && (left_l == ~IDX[0])) begin
            hold_q[i] <= IDX[1] ? word2_l : word1_l;
         end
      end

      // Frame copy, stable for the clk domain until the next frame
      always_ff @(posedge serial_bit_clock or negedge rst_n) begin
         if (!rst_n) begin
            outl_q[i] <= '0;
         end else if (pub_q) begin
            outl_q[i] <= hold_q[i];
         end
      end
   end

   // Publish one clock after the frame closes, so its last word is held
   always_ff @(posedge serial_bit_clock or negedge rst_n) begin
      if (!rst_n) begin
         pub_q  <= 1'b0;
         ftgl_q <= 1'b0;
         flen_q <= '0;
      end else begin
         pub_q <= frame_evt_l;                                                 // [RL25]
         if (frame_evt_l) begin
            // Stereo counter restarts each half; assumes two equal halves
            flen_q <= tdm_l ? cnt_q + 10'h001 : {cnt_q[asr_pkg::CNT_W-2:0], 1'b0} + 10'h002;
         end
         if (pub_q) begin
            ftgl_q <= ~ftgl_q;
         end
      end
   end

   // Master clock divider; may be the bit clock itself
   always_ff @(posedge master_audio_clock or negedge rst_n) begin
      if (!rst_n) begin
         mdiv_q <= '0;
      end else begin
         mdiv_q <= mdiv_q + 3'h1;                                              // [RL16]
      end
   end

   // Event toggles into the system clock
   asr_sync #(.W(2)) u_evt_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({mdiv_q[asr_pkg::MCLK_DIV_W-1], ftgl_q}),
      .q     ({mtgl_s, ftgl_s})
   );
   assign new_frame = ftgl_s ^ ftgl_p_q;

   // Master clock and halt counters per frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ftgl_p_q   <= 1'b0;
         mtgl_p_q   <= 1'b0;
         mcnt_q     <= 8'h00;
         halt_cnt_q <= '0;
      end else begin
         ftgl_p_q <= ftgl_s;
         mtgl_p_q <= mtgl_s;
         if (new_frame) begin
            mcnt_q     <= 8'h00;
            halt_cnt_q <= '0;
         end else begin
            if ((mtgl_s ^ mtgl_p_q) && (mcnt_q != 8'hFF)) begin
               mcnt_q <= mcnt_q + 8'h01;
            end
            if (halt_cnt_q != asr_pkg::HALT_LIMIT) begin
               halt_cnt_q <= halt_cnt_q + 11'h001;
            end
         end
      end
   end
   assign halt_w = (halt_cnt_q == asr_pkg::HALT_LIMIT);

   // Ratio checks; 48x stereo bit clock accepted as well
   assign len_good =
      (spc_q[asr_pkg::SPC_FMT_HI:asr_pkg::SPC_FMT_LO] == 2'(asr_pkg::ASR_FMT_TDM)) ?
      ((flen_q == asr_pkg::LEN_128FS) || (flen_q == asr_pkg::LEN_256FS)) :  // [RL15]
      ((flen_q == asr_pkg::LEN_32FS) || (flen_q == asr_pkg::LEN_48FS) ||
       (flen_q == asr_pkg::LEN_64FS));                                      // [RL3]
   // One count of slack absorbs the unrelated phase of the two clocks
   assign mclk_good =
      ((mcnt_q >= asr_pkg::MCLK_128 - asr_pkg::MCLK_TOL) &&
       (mcnt_q <= asr_pkg::MCLK_128 + asr_pkg::MCLK_TOL)) ||
      ((mcnt_q >= asr_pkg::MCLK_256 - asr_pkg::MCLK_TOL) &&
       (mcnt_q <= asr_pkg::MCLK_256 + asr_pkg::MCLK_TOL)) ||
      ((mcnt_q >= asr_pkg::MCLK_512 - asr_pkg::MCLK_TOL) &&
       (mcnt_q <= asr_pkg::MCLK_512 + asr_pkg::MCLK_TOL));  // [RL24]
   assign good_w = len_good & mclk_good;

   // Clock state and high impedance, recovers on the first good frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_ok_q   <= 1'b0;
         channels_hiz <= 1'b1;
      end else begin
         if (new_frame) begin
            frame_ok_q <= good_w;
         end
         channels_hiz <= ~(new_frame ? good_w : frame_ok_q) | (halt_w & ~new_frame);  // [RL22]
      end
   end

   // Downstream samples, one strobe per good frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_valid <= 1'b0;
         ch_sample_1  <= '0;
         ch_sample_2  <= '0;
         ch_sample_3  <= '0;
         ch_sample_4  <= '0;
      end else begin
         sample_valid <= new_frame & good_w;                                   // [RL25]
         if (new_frame && good_w) begin
            ch_sample_1 <= outl_q[0];
            ch_sample_2 <= outl_q[1];
            ch_sample_3 <= outl_q[2];
            ch_sample_4 <= outl_q[3];
         end
      end
   end

   // Checks, system clock
   chk_spc_write: assert property (@(posedge clk) disable iff (!rst_n) // [RL21]
      reg_wr_en && (reg_addr == asr_pkg::SPC_ADDR) |=>
      spc_q == ($past(reg_wdata) & asr_pkg::SPC_RW_MASK))
      else $error("control register write lost");
   chk_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n) // [RL21]
      reg_rd_en && (reg_addr != asr_pkg::SPC_ADDR) && (reg_addr != asr_pkg::PBS_ADDR) |=>
      reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_halt_hiz: assert property (@(posedge clk) disable iff (!rst_n) // [RL22]
      halt_w && !new_frame |=> channels_hiz)
      else $error("halted clock did not force high impedance");
   chk_valid_clean: assert property (@(posedge clk) disable iff (!rst_n) // [RL22]
      sample_valid |-> !channels_hiz && $past(good_w))
      else $error("strobe while clocks bad");
   chk_restore_play: assert property (@(posedge clk) disable iff (!rst_n) // [RL22]
      new_frame && good_w |=> !channels_hiz && sample_valid)
      else $error("no recovery after good frame");
   chk_valid_spacing: assert property (@(posedge clk) disable iff (!rst_n) // [RL25]
      sample_valid |=> !sample_valid [*8])
      else $error("strobes too close");

   // Checks, bit clock
   sequence s_frame_close;
      pub_q ##1 (ftgl_q != $past(ftgl_q));
   endsequence
   chk_publish_frame: assert property (@(posedge serial_bit_clock) disable iff (!rst_n) // [RL25]
      frame_evt_l |=> s_frame_close)
      else $error("frame not published");
   chk_i2s_left_low: assert property (@(posedge serial_bit_clock) disable iff (!rst_n) // [RL2]
      (fmt_l == asr_pkg::ASR_FMT_I2S) && cap_stereo_l && !fs_q |=> hold_q[0] == $past(word1_l))
      else $error("I2S word side wrong");
   chk_lj_left_high: assert property (@(posedge serial_bit_clock) disable iff (!rst_n) // [RL6]
      lj_l && cap_stereo_l && frame_sync |=> hold_q[0] == $past(word1_l))
      else $error("left-justified word side wrong");
   chk_lj_msb_now: assert property (@(posedge serial_bit_clock) disable iff (!rst_n) // [RL7]
      lj_l && restart_l |-> d_idx_l == '0 ##1 (restart_l || d_idx_l == 10'h001))
      else $error("left-justified MSB misplaced");
   chk_tdm_swap_map: assert property (@(posedge serial_bit_clock) disable iff (!rst_n) // [RL19]
      tdm_l && !cfg_l[asr_pkg::CFG_PB12] && cfg_l[asr_pkg::SPC_SWAP_BIT] |->
      map_l[0] == (map_l[2] ^ asr_pkg::SWAP_FLIP) && map_l[0][1])
      else $error("swapped slot order wrong");
   chk_paralleled_bridge_mode_slot: assert property (@(posedge serial_bit_clock) disable iff (!rst_n) // [RL20]
      tdm_l && cfg_l[asr_pkg::CFG_PB12] |->
      map_l[0] == map_l[1] && map_l[0][0] == cfg_l[asr_pkg::CFG_EVEN])
      else $error("bridged pair slot wrong");
endmodule : asr_receiver

//--- core/asr_pkg.sv
// Operation
// (RL1) Accepts I2S, left-justified, right-justified or multiplexed framing, set by config.
// (RL2) I2S: frame_sync low marks left word, high marks right word.
// (RL3) Host runs bit clock at 32 or 64 times sample rate in stereo framings.
// (RL4) I2S: first data bit comes one bit clock after the frame_sync change.
// (RL5) Samples are two's complement, MSB first, captured on bit clock rising edge.
// (RL6) Left-justified: frame_sync high marks left word, low marks right word.
// (RL7) Left-justified: MSB sits in the same bit period as the frame_sync change.
// (RL8) Left-justified: 16 or 24 bit words, trailing positions carry zeros.
// (RL9) Right-justified: frame_sync high marks left word, low marks right word.
// (RL10) Right-justified 24-bit in 32 clocks: MSB starts eight clocks after the change.
// (RL11) Right-justified: LSB falls in the last bit period before frame_sync changes.
// (RL12) Right-justified: leading unused positions are zero padding before the MSB.
// (RL13) Multiplexed framing carries 4 or 8 channels per frame.
// (RL14) Multiplexed framing accepts 16, 24 or 32 bit words.
// (RL15) Host runs bit clock at 128 or 256 times sample rate when multiplexed.
// (RL16) Multiplexed mode works with bit clock and master clock as one signal.
// (RL17) Multiplexed mode takes data from input 1 only; input 2 is ignored.
// (RL18) Configuration picks which slot pairs feed the four channels.
// (RL19) Control bit 5 picks slot group, bit 3 swaps order to 3,4,1,2.
// (RL20) Bridged pairs take one slot; 0x21 bit 6 picks odd or even slots.
// (RL21) Serial port settings live in one register at 0x03, reset 0x04.
// (RL22) Clock ratio error or halt forces all channels high impedance, auto recovery.
// (RL23) Host supplies frame_sync at 44.1, 48 or 96 kHz.
// (RL24) Host supplies master clock at 128, 256 or 512 times sample rate.
// (RL25) Each channel sample goes downstream with one valid strobe per frame.
package asr_pkg;
   // Register map
   localparam logic [7:0] SPC_ADDR    = 8'h03;
   localparam logic [7:0] SPC_RESET   = 8'h04;
   localparam logic [7:0] SPC_RW_MASK = 8'hEF;  // Bit 4 reserved, reads zero
   localparam logic [7:0] PBS_ADDR    = 8'h21;
   localparam logic [7:0] PBS_RESET   = 8'h00;
   localparam logic [7:0] PBS_RW_MASK = 8'h40;
   // Field positions
   localparam int SPC_FMT_HI     = 7;
   localparam int SPC_FMT_LO     = 6;
   localparam int SPC_GROUP_BIT  = 5;
   localparam int SPC_SWAP_BIT   = 3;
   localparam int SPC_SLOTS8_BIT = 2;
   localparam int SPC_WLEN_HI    = 1;
   localparam int SPC_WLEN_LO    = 0;
   localparam int PBS_EVEN_BIT   = 6;
   // Configuration word carried into the link domain
   localparam int CFG_W    = 11;
   localparam int CFG_EVEN = 8;
   localparam int CFG_PB12 = 9;
   localparam int CFG_PB34 = 10;
   typedef enum logic [1:0] {ASR_FMT_I2S, ASR_FMT_LJ, ASR_FMT_RJ, ASR_FMT_TDM} asr_fmt_t;
   typedef enum logic [1:0] {ASR_WL_16, ASR_WL_24, ASR_WL_32, ASR_WL_24B} asr_wlen_t;
   localparam int SAMPLE_W = 32;
   localparam int CNT_W    = 10;
   // Last bit index of a word
   localparam logic [4:0] LAST_16 = 5'h0F;
   localparam logic [4:0] LAST_24 = 5'h17;
   localparam logic [4:0] LAST_32 = 5'h1F;
   // Data bits per multiplexed frame
   localparam logic [9:0] TDM4_16 = 10'h040;
   localparam logic [9:0] TDM4_32 = 10'h080;
   localparam logic [9:0] EIGHT_SLOT_MULTIPLEX_16 = 10'h080;
   localparam logic [9:0] EIGHT_SLOT_MULTIPLEX_32 = 10'h100;
   localparam logic [2:0] GROUP_BASE = 3'h4;
   localparam logic [2:0] SWAP_FLIP  = 3'h2;
   // Bit clocks per frame that are accepted
   localparam logic [9:0] LEN_32FS  = 10'h020;
   localparam logic [9:0] LEN_48FS  = 10'h030;
   localparam logic [9:0] LEN_64FS  = 10'h040;
   localparam logic [9:0] LEN_128FS = 10'h080;
   localparam logic [9:0] LEN_256FS = 10'h100;
   // Master clock divided by eight: its top bit changes ratio/4 times per frame
   localparam int         MCLK_DIV_W = 3;
   localparam logic [7:0] MCLK_128   = 8'h20;
   localparam logic [7:0] MCLK_256   = 8'h40;
   localparam logic [7:0] MCLK_512   = 8'h80;
   localparam logic [7:0] MCLK_TOL   = 8'h01;
   // Halt timeout
   localparam int          CLK_PERIOD_NS = 20;
   localparam int          HALT_TIME_NS  = 40000;
   localparam int          HALT_CYCLES   = HALT_TIME_NS / CLK_PERIOD_NS;
   localparam int          HALT_W        = 11;
   localparam logic [10:0] HALT_LIMIT    = 11'(HALT_CYCLES);
endpackage : asr_pkg

//--- core/asr_sync.sv
`timescale 1ns/10ps
module asr_sync #(
   parameter int W = 1                    // Bits synchronised
) (
   input  wire logic         clk,         // Destination clock
   input  wire logic         rst_n,       // Async reset, active low
   input  wire logic [W-1:0] d,           // Level from other domain
   output logic      [W-1:0] q            // Synchronised level
);
   logic [W-1:0] meta_q;

   // Two stages; first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : asr_sync

//--- tb/asr_host_model.sv
`timescale 1ns/10ps
module asr_host_model (
   output logic serial_bit_clock,   // Bit clock, still between bursts
   output logic frame_sync,         // Frame sync
   output logic serial_data_in_1,   // Data line 1
   output logic serial_data_in_2,   // Data line 2
   output logic master_audio_clock  // Master clock, free running
);
   // Four master clocks a bit clock: 128/256/512 fs at 32/64/128 fs
   // Frame rate scaled up to keep runs short
   initial begin
      {serial_bit_clock, frame_sync, serial_data_in_1, serial_data_in_2} = 4'h0;
      master_audio_clock = 1'b0;
      forever #8 master_audio_clock = ~master_audio_clock;
   end
   // Frames of h clocks a half fmt 0 I2S, 1 left, 2 right justified
   // fmt 3 multiplexed: 2h clocks four 32-clock slots, sync high first half
   task automatic send(input int fmt, h, n, nfr, input logic [23:0] w [4]);
      int j, k, hf;
      for (int i = 0; i < nfr * 2 * h; i++) begin
         hf = (i / h) % 2;
         frame_sync = (fmt == 0) ? hf[0] : !hf[0];  // Left level
         j = i - ((fmt == 0 || fmt == 3) ? 1 : 0);  // Delay bit, LSB spills over
         hf = (fmt == 3) ? (j % (2 * h)) / 32 : (j / h) % 2;  // Word being sent
         k = ((fmt == 3) ? j % 32 : j % h) - ((fmt == 2) ? h - n : 0);
         serial_data_in_1 = (j >= 0 && k >= 0 && k < n) ? w[hf][n-1-k] : 1'b0;
         serial_data_in_2 = (fmt == 3) ? 1'b0 :  // Grounded when multiplexed
            (j >= 0 && k >= 0 && k < n) ? w[2+hf][n-1-k] : 1'b0;
         #32 serial_bit_clock = 1'b1;  // Data settled half a bit early
         #32 serial_bit_clock = 1'b0;
      end
   endtask : send
endmodule : asr_host_model

//--- tb/asr_receiver_test.sv
`timescale 1ns/10ps
module asr_receiver_test;
   logic        clk, rst_n, serial_bit_clock, frame_sync, serial_data_in_1, serial_data_in_2;
   logic        master_audio_clock, paralleled_bridge_12, paralleled_bridge_34;
   logic        reg_wr_en, reg_rd_en, sample_valid, channels_hiz;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [31:0] ch_sample_1, ch_sample_2, ch_sample_3, ch_sample_4;
   int          n_errors, total_checks;
   logic [23:0] w [4] = '{24'hA5C3F1, 24'h5A3C0F, 24'h812345, 24'h7FEDCB};
   asr_receiver dut (.*);
   asr_host_model host (.*);
   initial begin  // 50 MHz
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin  // Watchdog, the tests need about 130 us
      #400000 n_errors++;
      conclude();
   end
   task automatic check(input logic [127:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask : check
   // Register access; reg_rdata is valid after the edge that takes a read
   task automatic bus(input logic we, input logic [7:0] a, d);
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr_en, reg_rd_en} <= {a, d, we, !we};
      @(posedge clk);
      {reg_wr_en, reg_rd_en} <= 2'b00;
      #1;
   endtask : bus
   task automatic t_regs();
      bus(0, 8'h03, 8'h00);
      check(reg_rdata, 8'h04);
      bus(1, 8'h03, 8'hFF);
      bus(0, 8'h03, 8'h00);
      check(reg_rdata, 8'hEF);
      bus(0, 8'h5A, 8'h00);
      check(reg_rdata, 8'h00);  // Unmapped address reads zero
      bus(1, 8'h21, 8'hFF);
      bus(0, 8'h21, 8'h00);
      check(reg_rdata, 8'h40);
   endtask : t_regs
   // Multiplexed, 24-bit words in 32-bit slots; s gives each channel's slot
   task automatic t_tdm(input logic [7:0] cfg, input int s [4]);
      logic [127:0] e;
      foreach (w[i]) w[i] = ~w[i];
      bus(1, 8'h03, cfg);
      host.send(3, 64, 24, 3, w);
      repeat (12) @(posedge clk);
      for (int i = 0; i < 4; i++) e = {e[95:0], w[s[i]], 8'h00};
      check({ch_sample_1, ch_sample_2, ch_sample_3, ch_sample_4}, e);
      check(channels_hiz, 1'b0);
   endtask : t_tdm
   // Three frames; the first close after a pause sees a stale frame
   task automatic t_stereo(input logic [7:0] cfg, input int fmt, h, n);
      logic [127:0] e;
      foreach (w[i]) w[i] = ~w[i];
      bus(1, 8'h03, cfg);
      host.send(fmt, h, n, 3, w);
      repeat (12) @(posedge clk);
      for (int i = 0; i < 4; i++) e = {e[95:0], {w[i], 8'h00} << (24 - n)};
      check({ch_sample_1, ch_sample_2, ch_sample_3, ch_sample_4}, e);
      check(channels_hiz, 1'b0);
   endtask : t_stereo
   task automatic conclude();
      $display("checks %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   initial begin
      {rst_n, reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
      {paralleled_bridge_12, paralleled_bridge_34} = 2'b00;  // Bridging acts only in TDM
      host.send(0, 1, 1, 1, w);  // Two bit clock edges inside reset
      repeat (12) @(posedge clk);
      check(channels_hiz, 1'b1);
      rst_n <= 1'b1;
      t_regs();
      t_stereo(8'h04, 0, 16, 16);
      repeat (2100) @(posedge clk);
      check(channels_hiz, 1'b1);  // Bit clock halted
      t_stereo(8'h45, 1, 32, 24);
      t_stereo(8'h85, 2, 32, 24);
      t_tdm(8'hC9, '{2, 3, 0, 1});  // Swapped order, four slots
      paralleled_bridge_12 <= 1'b1;
      t_tdm(8'hC1, '{1, 1, 2, 3});  // Bridged 1/2 on the even slot
      conclude();
   end
endmodule : asr_receiver_test
